/* hw/flash_boot_command_sequencer.sv */
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
module flash_boot_command_sequencer
    import flash_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic wdt_reset_in,
    input wire logic boot_select_in,
    input wire logic address_mode_pin_zero_in,
    input wire logic address_mode_pin_one_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    output logic single_chip_out,
    output logic single_boot_out,
    output logic busy_out,
    output logic irq_out
);
    logic rst_s1_q, rst_n_q;
    logic [2:0] pin_s1_q, pin_s2_q;
    logic capture_q;
    engine_state_t state_q;
    logic [2:0] step_q;
    logic [WADDR_W-1:0] pa_q, walk_q;
    logic [DATA_W-1:0] pd_q;
    logic [NBLK-1:0] blk_mask_q;
    logic [CNT_W-1:0] cnt_q;
    logic toggle_q;
    logic [1:0] irq_stat_q, irq_mask_q;
    logic [WADDR_W-1:0] mem_addr;
    logic mem_we, mem_load, alt_sel;
    logic [DATA_W-1:0] mem_wdata, alt_data, old_word, status_word;
    logic reg_space, flash_wr, at_a, at_5;
    logic [7:0] cmd;
    logic go_reset, go_prog, go_chip, go_block, seq_bad;
    logic op_done, op_fail;
    logic [NBLK-1:0] wr_blk;

    function automatic logic [NBLK-1:0] block_of(input logic [WADDR_W-1:0] w);
        logic [4:0] a;
        a = w[16:12];
        block_of = '0;
        case (a[4:3])
            2'b00: block_of[0] = 1'b1;
            2'b01: block_of[1] = 1'b1;
            2'b10: block_of[2] = 1'b1;
            default: begin
                if (!a[2]) block_of[3] = 1'b1;
                else if (a[1]) block_of[6] = 1'b1;
                else if (a[0]) block_of[5] = 1'b1;
                else block_of[4] = 1'b1;
            end
        endcase
    endfunction

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Mode pins come from the board; the synchroniser runs through reset so live levels wait
    always_ff @(posedge clk_in) begin
        pin_s1_q <= {boot_select_in, address_mode_pin_one_in, address_mode_pin_zero_in};
        pin_s2_q <= pin_s1_q;
    end

    // Capture waits two edges after release so the synchroniser holds live pin levels
    logic cap_wait_q;
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cap_wait_q <= 1'b1;
            capture_q <= 1'b1;
        end else begin
            cap_wait_q <= wdt_reset_in;
            capture_q <= cap_wait_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            single_chip_out <= 1'b0;
            single_boot_out <= 1'b0;
        end else if (capture_q && !cap_wait_q) begin
            single_chip_out <= pin_s2_q[2];
            single_boot_out <= !pin_s2_q[2] && pin_s2_q[1] && pin_s2_q[0];
        end
    end

    assign reg_space = addr_in[REG_SPACE_BIT];
    assign flash_wr = wr_in && !reg_space;
    assign cmd = wdata_in[7:0];
    assign at_a = addr_in[15:0] == CMD_ADDR_A;
    assign at_5 = addr_in[15:0] == CMD_ADDR_5;
    assign wr_blk = block_of(addr_in[17:1]);

    // Protection commands fall into seq_bad and simply cancel the sequence
    always_comb begin
        go_reset = 1'b0;
        go_prog = 1'b0;
        go_chip = 1'b0;
        go_block = 1'b0;
        seq_bad = 1'b0;
        if (flash_wr) begin
            case (step_q)
                3'd0: begin
                    go_reset = cmd == CMD_RESET;
                    seq_bad = !(at_a && cmd == CMD_UNLOCK1);
                end
                3'd1: seq_bad = !(at_5 && cmd == CMD_UNLOCK2);
                3'd2: begin
                    go_reset = at_a && cmd == CMD_RESET;
                    seq_bad = !(at_a && (cmd == CMD_PROGRAM || cmd == CMD_ERASE));
                end
                3'd3: go_prog = 1'b1;
                3'd4: seq_bad = !(at_a && cmd == CMD_UNLOCK1);
                3'd5: seq_bad = !(at_5 && cmd == CMD_UNLOCK2);
                3'd6: begin
                    go_chip = at_a && cmd == CMD_CHIP;
                    go_block = cmd == CMD_BLOCK;
                    seq_bad = !(go_chip || go_block);
                end
                default: seq_bad = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            step_q <= 3'd0;
        end else if (wdt_reset_in) begin
            step_q <= 3'd0;
        end else if (flash_wr && (state_q == S_READ || state_q == S_FAIL)) begin
            if (seq_bad || go_reset || go_prog || go_chip || go_block) begin
                step_q <= 3'd0;
            end else if (step_q == 3'd2 && cmd == CMD_PROGRAM) begin
                step_q <= 3'd3;
            end else if (step_q == 3'd2) begin
                step_q <= 3'd4;
            end else begin
                step_q <= step_q + 3'd1;
            end
        end
    end

    assign old_word = rdata_out;

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= S_READ;
            pa_q <= '0;
            pd_q <= '0;
            blk_mask_q <= '0;
            walk_q <= '0;
            cnt_q <= '0;
        end else if (wdt_reset_in) begin
            state_q <= S_READ;
        end else begin
            case (state_q)
                S_READ: begin
                    walk_q <= '0;
                    cnt_q <= '0;
                    if (go_prog) begin
                        pa_q <= addr_in[17:1];
                        pd_q <= wdata_in;
                        blk_mask_q <= '0;
                        state_q <= S_PROG_RD;
                    end else if (go_chip) begin
                        blk_mask_q <= ALL_BLOCKS;
                        state_q <= S_ERASE_RUN;
                    end else if (go_block) begin
                        blk_mask_q <= wr_blk;
                        state_q <= S_ERASE_HOLD;
                    end
                end
                S_PROG_RD: state_q <= S_PROG_CHK;
                S_PROG_CHK: begin
                    // Cells only go from 1 to 0; a word needing a 0 to rise fails
                    if ((old_word & pd_q) != pd_q) state_q <= S_FAIL;
                    else state_q <= S_PROG_RUN;
                end
                S_PROG_RUN: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(PROG_CYCLES - 1)) state_q <= S_READ;
                end
                S_ERASE_HOLD: begin
                    if (flash_wr && cmd == CMD_BLOCK) begin
                        blk_mask_q <= blk_mask_q | wr_blk;
                        cnt_q <= '0;
                    end else if (cnt_q == CNT_W'(HOLD_CYCLES - 1)) begin
                        state_q <= S_ERASE_RUN;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_ERASE_RUN: begin
                    walk_q <= walk_q + 1'b1;
                    if (walk_q == WADDR_W'(WORDS - 1)) state_q <= S_READ;
                end
                S_FAIL: begin
                    if (go_reset) state_q <= S_READ;
                end
                default: state_q <= S_READ;
            endcase
        end
    end

    assign op_done = (state_q == S_PROG_RUN && cnt_q == CNT_W'(PROG_CYCLES - 1))
        || (state_q == S_ERASE_RUN && walk_q == WADDR_W'(WORDS - 1));
    assign op_fail = state_q == S_PROG_CHK && (old_word & pd_q) != pd_q;

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            toggle_q <= 1'b0;
        end else if (rd_in && !reg_space && state_q != S_READ) begin
            toggle_q <= !toggle_q;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[ST_POLL] = (state_q == S_PROG_RUN || state_q == S_PROG_CHK
            || state_q == S_PROG_RD || (state_q == S_FAIL && blk_mask_q == '0))
            ? !pd_q[ST_POLL] : 1'b0;
        status_word[ST_TOGGLE] = !toggle_q;
        status_word[ST_TIMEOUT] = state_q == S_FAIL;
        status_word[ST_ERASE_PH] = state_q == S_ERASE_RUN || state_q == S_FAIL;
    end

    always_comb begin
        alt_sel = 1'b1;
        alt_data = '0;
        if (reg_space) begin
            case (addr_in[3:0])
                REG_IRQ_STATUS: alt_data = {14'h0000, irq_stat_q};
                REG_IRQ_MASK: alt_data = {14'h0000, irq_mask_q};
                REG_ENGINE: alt_data = {13'h0000, state_q};
                default: alt_data = '0;
            endcase
        end else if (state_q != S_READ) begin
            alt_data = status_word;
        end else begin
            alt_sel = 1'b0;
        end
    end

    always_comb begin
        mem_addr = addr_in[17:1];
        mem_we = 1'b0;
        mem_wdata = pd_q;
        mem_load = rd_in;
        if (state_q == S_PROG_RD) begin
            mem_addr = pa_q;
            mem_load = 1'b1;
        end else if (state_q == S_PROG_CHK) begin
            mem_addr = pa_q;
            mem_wdata = old_word & pd_q;
            mem_we = (old_word & pd_q) == pd_q;
        end else if (state_q == S_ERASE_RUN) begin
            mem_addr = walk_q;
            mem_wdata = ERASED_WORD;
            mem_we = |(block_of(walk_q) & blk_mask_q);
        end
    end

    flash_array_mem u_array (
        .clk_in(clk_in),
        .addr_in(mem_addr),
        .we_in(mem_we),
        .wdata_in(mem_wdata),
        .load_in(mem_load),
        .alt_sel_in(alt_sel && state_q != S_PROG_RD),
        .alt_data_in(alt_data),
        .rdata_out(rdata_out)
    );

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            if (wr_in && reg_space && addr_in[3:0] == REG_IRQ_MASK) begin
                irq_mask_q <= wdata_in[1:0];
            end
            irq_stat_q[IRQ_DONE] <= op_done ||
                (irq_stat_q[IRQ_DONE] && !(wr_in && reg_space
                && addr_in[3:0] == REG_IRQ_STATUS && wdata_in[IRQ_DONE]));
            irq_stat_q[IRQ_FAIL] <= op_fail ||
                (irq_stat_q[IRQ_FAIL] && !(wr_in && reg_space
                && addr_in[3:0] == REG_IRQ_STATUS && wdata_in[IRQ_FAIL]));
            irq_out <= |(irq_stat_q & irq_mask_q);
            busy_out <= state_q != S_READ && state_q != S_FAIL;
        end
    end
endmodule

/* hw/flash_seq_pkg.sv */
// Contract
// - Operating mode is taken from mode pins when leaving any reset, watchdog included.
// - Single-chip mode starts the CPU from internal flash right after reset.
// - Single-boot mode starts the boot ROM rewrite routine after reset.
// - Array holds 256 KB, as bytes or as 128K 16-bit words. The code gives word access only and ignores addr_in[0].
// - After a full sequence, program or erase runs internally with no bus help.
// - Chip erase, single-block erase and multi-block erase are supported.
// - No block protection; protection commands have no protective effect.
// - Read/reset is F0 to any address, or unlock prefix then F0 at AAAA.
// - Program is AA@AAAA, 55@5554, A0@AAAA, then address and data word.
// - Erase is prefix, 80, prefix, then 10@AAAA (chip) or 30@block (block).
// - Commands use low eight data bits only; a wrong sequence returns to read mode.
// - Status: bit7 inverted data or 0, bit6 toggles, bit5 timeout, bit3 erase phase.
// - A failed operation stays locked until the reset command arrives.
// - Erase block chosen by address bits 17..13; blocks 64,64,64,32,8,8,16 KB.
package flash_seq_pkg;
    localparam int ADDR_W = 19;
    localparam int WADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int WORDS = 131072;
    localparam int NBLK = 7;
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_TIME_NS = 20000;
    localparam int ERASE_HOLD_NS = 50000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES = (ERASE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam logic [15:0] CMD_ADDR_A = 16'hAAAA;
    localparam logic [15:0] CMD_ADDR_5 = 16'h5554;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_BLOCK = 8'h30;
    localparam int REG_SPACE_BIT = 18;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_MASK = 4'h4;
    localparam logic [3:0] REG_ENGINE = 4'h8;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAIL = 1;
    localparam int ST_POLL = 7;
    localparam int ST_TOGGLE = 6;
    localparam int ST_TIMEOUT = 5;
    localparam int ST_ERASE_PH = 3;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
    localparam logic [NBLK-1:0] ALL_BLOCKS = 7'h7F;
    typedef enum logic [2:0] {
        S_READ = 3'h0,
        S_PROG_RD = 3'h1,
        S_PROG_CHK = 3'h3,
        S_PROG_RUN = 3'h2,
        S_ERASE_HOLD = 3'h6,
        S_ERASE_RUN = 3'h7,
        S_FAIL = 3'h5
    } engine_state_t;
endpackage

/* hw/flash_array_mem.sv */
`timescale 1ns/10ps
module flash_array_mem
    import flash_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic [WADDR_W-1:0] addr_in,
    input wire logic we_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic load_in,
    input wire logic alt_sel_in,
    input wire logic [DATA_W-1:0] alt_data_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem [WORDS];

    // Alternate word shares the output register so bus read data leave from one flop
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        if (load_in) begin
            rdata_out <= alt_sel_in ? alt_data_in : mem[addr_in];
        end
    end
endmodule

/* bench/flash_seq_props.sv */
`timescale 1ns/10ps
module flash_seq_props
    import flash_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic wdt_reset_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic single_chip_out,
    input wire logic single_boot_out,
    input wire logic busy_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    logic [3:0] up_q;
    logic [1:0] run_q;
    logic lock_q;
    wire fl_wr = wr_in && !addr_in[REG_SPACE_BIT];
    wire reg_rd = rd_in && addr_in[REG_SPACE_BIT];
    wire first_ok = fl_wr && addr_in[15:0] == CMD_ADDR_A && wdata_in[7:0] == CMD_UNLOCK1
        && !busy_out && !lock_q;
    // A failed program shows busy for two cycles only; the engine then waits for reset
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_q <= 2'h0;
            lock_q <= 1'b0;
        end else begin
            run_q <= !busy_out ? 2'h0 : (run_q == 2'h3) ? run_q : run_q + 2'h1;
            if (wdt_reset_in || (fl_wr && wdata_in[7:0] == CMD_RESET)) begin
                lock_q <= 1'b0;
            end else if (!busy_out && run_q == 2'h2) begin
                lock_q <= 1'b1;
            end
        end
    end
    // Mode outputs settle some cycles after release, so that window is skipped
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            up_q <= 4'h0;
        end else if (up_q != 4'hF) begin
            up_q <= up_q + 4'h1;
        end
    end
    sequence cmd_s(logic [7:0] c);
        fl_wr && addr_in[15:0] == CMD_ADDR_A && wdata_in[7:0] == c;
    endsequence
    sequence unlock_s;
        first_ok ##1 fl_wr && addr_in[15:0] == CMD_ADDR_5 && wdata_in[7:0] == CMD_UNLOCK2;
    endsequence
    a_prog_start: assert property (unlock_s ##1 cmd_s(CMD_PROGRAM) ##1 fl_wr |-> ##2 busy_out)
        else $error("program did not start");
    a_erase_start: assert property (unlock_s ##1 cmd_s(CMD_ERASE) ##1 unlock_s
        ##1 (cmd_s(CMD_CHIP) or (fl_wr && wdata_in[7:0] == CMD_BLOCK)) |-> ##2 busy_out)
        else $error("erase did not start");
    a_wrong_seq: assert property (first_ok ##1 fl_wr && wdata_in[7:0] != CMD_UNLOCK2
        ##1 cmd_s(CMD_PROGRAM) ##1 fl_wr |-> ##2 !busy_out [*3])
        else $error("broken sequence accepted");
    a_reset_cmd: assert property (fl_wr && wdata_in[7:0] == CMD_RESET && !busy_out
        ##1 reg_rd && addr_in[3:0] == REG_ENGINE |=> rdata_out == 16'h0000)
        else $error("reset command ignored");
    a_unmapped_zero: assert property (reg_rd && addr_in[3:0] == 4'hC |=> rdata_out == 16'h0000)
        else $error("unmapped register not zero");
    a_irq_masked: assert property (wr_in && addr_in[REG_SPACE_BIT] && addr_in[3:0] == REG_IRQ_MASK
        && wdata_in == 16'h0000 |-> ##2 !irq_out)
        else $error("masked interrupt still high");
    a_mode_excl: assert property (!(single_chip_out && single_boot_out))
        else $error("two modes at once");
    a_mode_hold: assert property (up_q == 4'hF && $changed({single_chip_out, single_boot_out})
        |-> $past(wdt_reset_in) || $past(wdt_reset_in, 2) || $past(wdt_reset_in, 3)
        || $past(wdt_reset_in, 4))
        else $error("mode changed without reset");
    a_poll_status: assert property (rd_in && !addr_in[REG_SPACE_BIT] && busy_out ##1 busy_out
        |-> rdata_out[ST_TIMEOUT] == 1'b0)
        else $error("timeout flag while running");
endmodule
bind flash_boot_command_sequencer flash_seq_props u_props (.clk_in, .nrst_in, .wdt_reset_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .single_chip_out, .single_boot_out,
    .busy_out, .irq_out);

/* bench/cpu_bus_model.sv */
`timescale 1ns/10ps
module cpu_bus_model
    import flash_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic [DATA_W-1:0] rdata_in,
    output logic [ADDR_W-1:0] addr_out = '0,
    output logic [DATA_W-1:0] wdata_out = '0,
    output logic wr_out = 1'b0,
    output logic rd_out = 1'b0
);
    // Strobe is left high so a following call can run with no idle cycle
    task wr_cyc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        rd_out <= 1'b0;
    endtask
    task rd_cyc(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wr_out <= 1'b0;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1 d = rdata_in;
    endtask
    // Released lines show inverted values so a stale bus never looks valid
    task idle;
        @(posedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        addr_out <= ~addr_out;
        wdata_out <= ~wdata_out;
    endtask
    task cmd(input logic [7:0] c);
        wr_cyc({3'b000, CMD_ADDR_A}, {8'hC3, c});
    endtask
    task unlock;
        wr_cyc({3'b010, CMD_ADDR_A}, {8'h5A, CMD_UNLOCK1});
        wr_cyc({3'b000, CMD_ADDR_5}, {8'hA5, CMD_UNLOCK2});
    endtask
endmodule

/* bench/flash_boot_command_sequencer_tb.sv */
`timescale 1ns/10ps
module flash_boot_command_sequencer_tb;
    import flash_seq_pkg::*;
    localparam logic [ADDR_W-1:0] PA = 19'h3FFFE;
    localparam logic [ADDR_W-1:0] CA = {3'b000, CMD_ADDR_A};
    localparam logic [ADDR_W-1:0] C5 = {3'b000, CMD_ADDR_5};
    localparam logic [ADDR_W-1:0] STA = {1'b1, 14'h0000, REG_IRQ_STATUS};
    localparam logic [ADDR_W-1:0] MSK = {1'b1, 14'h0000, REG_IRQ_MASK};
    localparam logic [ADDR_W-1:0] ENG = {1'b1, 14'h0000, REG_ENGINE};
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic wdt = 1'b0;
    logic boot = 1'b1;
    logic am0 = 1'b1;
    logic am1 = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d, d1;
    logic wr, rd, chip, sboot, busy, irq;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    always #12.5 clk_in = ~clk_in;
    cpu_bus_model u_cpu (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd));
    flash_boot_command_sequencer u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .wdt_reset_in(wdt),
        .boot_select_in(boot), .address_mode_pin_zero_in(am0), .address_mode_pin_one_in(am1),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .single_chip_out(chip), .single_boot_out(sboot), .busy_out(busy), .irq_out(irq));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task final_report;
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        u_cpu.rd_cyc(a, d);
        chk(d, exp);
    endtask
    task slow(input logic [ADDR_W-1:0] a, input logic [15:0] v);
        u_cpu.wr_cyc(a, v);
        u_cpu.idle();
    endtask
    task prog(input logic [15:0] v);
        u_cpu.unlock();
        u_cpu.cmd(CMD_PROGRAM);
        slow(PA, v);
    endtask
    task erase(input logic [ADDR_W-1:0] a, input logic [7:0] c);
        u_cpu.unlock();
        u_cpu.cmd(CMD_ERASE);
        u_cpu.unlock();
        slow(a, {8'h00, c});
        step(4);
    endtask
    task wdt_pulse;
        @(posedge clk_in);
        wdt <= 1'b1;
        @(posedge clk_in);
        wdt <= 1'b0;
        step(6);
    endtask
    // Whole run needs about 950 cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end
    initial begin
        // Array leaves the factory erased
        for (int i = 0; i < WORDS; i++) u_dut.u_array.mem[i] = ERASED_WORD;
        step(12);
        nrst_in <= 1'b1;
        step(8);
        chk({chip, sboot}, 2'b10);
        rd_chk({1'b1, 18'h0000C}, 16'h0000);
        slow(MSK, 16'h0003);
        prog(16'h1234);
        u_cpu.rd_cyc(PA, d1);
        u_cpu.rd_cyc(PA, d);
        chk({d1[ST_POLL], d1[ST_TIMEOUT], d1[ST_ERASE_PH]}, 3'b100);
        chk({d1[ST_TOGGLE], d[ST_TOGGLE], busy}, 3'b101);
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) step(1);
        rd_chk(PA, 16'h1234);
        rd_chk(STA, 16'h0001);
        chk(irq, 1'b1);
        slow(STA, 16'h0001);
        step(2);
        chk(irq, 1'b0);
        prog(16'hFFFF);
        step(8);
        u_cpu.rd_cyc(PA, d);
        chk({d[ST_POLL], d[ST_TIMEOUT], d[ST_ERASE_PH], irq}, 4'b0111);
        slow(CA, 16'h00AA);
        slow(C5, 16'h0055);
        slow(CA, 16'h00A0);
        slow(19'h00400, 16'h0000);
        rd_chk(ENG, {13'h0000, S_FAIL});
        slow(CA, 16'h00AA);
        slow(C5, 16'h0055);
        slow(CA, 16'h00F0);
        rd_chk(ENG, 16'h0000);
        rd_chk(PA, 16'h1234);
        u_cpu.wr_cyc(19'h01234, 16'h77F0);
        rd_chk(ENG, 16'h0000);
        u_cpu.wr_cyc(STA, 16'h0003);
        slow(MSK, 16'h0000);
        step(2);
        chk(irq, 1'b0);
        u_cpu.wr_cyc(CA, 16'h00AA);
        u_cpu.wr_cyc(C5, 16'h0056);
        u_cpu.cmd(CMD_PROGRAM);
        slow(PA, 16'h0000);
        step(3);
        chk(busy, 1'b0);
        rd_chk(PA, 16'h1234);
        erase(19'h3C000, CMD_BLOCK);
        rd_chk(ENG, {13'h0000, S_ERASE_HOLD});
        u_cpu.rd_cyc(PA, d);
        chk({d[ST_POLL], d[ST_ERASE_PH], busy}, 3'b001);
        boot <= 1'b0;
        step(4);
        wdt_pulse();
        rd_chk(ENG, 16'h0000);
        chk({chip, sboot}, 2'b01);
        erase(CA, CMD_CHIP);
        rd_chk(ENG, {13'h0000, S_ERASE_RUN});
        u_cpu.rd_cyc(PA, d);
        chk(d[ST_ERASE_PH], 1'b1);
        am0 <= 1'b0;
        step(4);
        wdt_pulse();
        chk({chip, sboot}, 2'b00);
        final_report();
    end
endmodule
